// ---- hfr_ctrl.sv ----
// frame fifo controller: receive and transmit buffers behind apb
// How it works
// - overflowing frame marks status byte overflow flag
// - frame arriving into full buffer raises lost
// - reads beyond data repeat last byte
// - block ack releases block, unread bytes dropped
// - unannounced reads leave buffer contents intact
// - status byte closes every stored frame
// - address bits reported only in proper modes
// - status carries crc, valid, abort, overflow
// - count registers give length, overflow
// - 64-byte transmit buffer, 16 or 32 blocks
// - pool ready after transmitter reset and freed block
// - empty mid-frame aborts with underrun event
// - late collision stops sender, repeat event
// - underrun or repeat clear, block writes
// - frame command starts send with opening flag
// - end command closes frame with check, flag
// - transmitter reset clears, aborts, keeps events
// - too many written bytes set overflow flag
// - write-enable flag shows buffer accepts data
// - pool ready once a block is free
// - frame plus end locks until closing flag
// - block size defaults 32, latched by commands
// - receive threshold 32,16,8,4 from field
// - no new receive event before block ack
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
module hfr_ctrl
    import hfr_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive link
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_eof,
    input wire logic rx_crc_ok,
    input wire logic rx_vfr,
    input wire logic rx_abort,
    input wire logic rx_cr,
    input wire logic [1:0] rx_sapi,
    input wire logic rx_tei,
    // transmit link
    input wire logic tx_req,
    input wire logic tx_collision,
    input wire logic tx_close_done,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_first,
    output logic tx_last,
    output logic tx_abort
);

    typedef struct packed {
        logic [63:0][7:0] rm;
        logic [5:0] rwp, rbase, rlen, rfill;
        logic [6:0] rused, roff;
        logic [7:0] rlast, cntl;
        logic [4:0] cnth;
        logic [1:0] rthr, qw, qr;
        logic [2:0] qn;
        logic rin, rlost, rdov, rov, rown;
        logic [11:0] rcnt;
        hfr_ev_s [QN-1:0] q;
        logic [7:0] irq, xmode;
        logic [2:0] mode;
        logic [31:0] prdata;
        logic [63:0][7:0] xm;
        logic [5:0] xwp, xrd, xcm, xfs, xend;
        logic [6:0] xused, xblkw, xsent;
        logic xend_v, xbs, tx_overflow_flag, xwait, xlock, xdrop;
        hfr_tx_e st;
        logic tv, tf, tl, ta;
        logic [7:0] td;
    } hfr_st_s;

    hfr_st_s r, n;
    logic setup, acc, wr, rdacc, cmd, unmapped, take, rinc, xinc, xdec, rclr, xclr;
    logic qpush, qpop;
    logic [6:0] rdec, ravail, xfree, bs;
    logic [5:0] rptr;
    logic [7:0] sbyte, ev_set;
    logic [12:0] cinc;
    hfr_ev_s qin, qout;
    logic cr_ok, ta_ok;

    // frame length counter step, sticking at the top
    function automatic logic [12:0] hfr_cnt_inc(input logic ov, input logic [11:0] c);
        return (c == CNT_MAX) ? {1'b1, c} : {ov, c + 12'h001};
    endfunction : hfr_cnt_inc

    // bus phases and decode
    assign setup = psel & ~penable;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rdacc = acc & ~pwrite;
    assign cmd = wr & (paddr == ADR_CMD);
    assign unmapped = (paddr[1:0] != 2'b00) || (paddr > ADR_MODE);
    assign pready = 1'b1;
    assign pslverr = acc & unmapped;

    // derived levels
    assign bs = hfr_tx_thr(r.xbs);
    assign xfree = DEPTH - r.xused;
    assign ravail = r.rown ? {1'b0, r.rlen} : r.rused;
    assign rptr = r.rbase + r.roff[5:0];
    assign cinc = hfr_cnt_inc(r.rov, r.rcnt);
    assign qout = r.q[r.qr];
    assign take = tx_req & ~tx_collision & (r.xrd != r.xcm) & (r.st != TX_CLOSE);

    // status byte: address bits gated by mode
    assign cr_ok = (r.mode == MODE_NA2) || (r.mode == MODE_T1);
    assign ta_ok = (r.mode != MODE_T0) && (r.mode != MODE_T1);
    always_comb begin
        sbyte = '0;
        sbyte[SB_VFR] = rx_vfr;
        sbyte[SB_RDO] = r.rdov;
        sbyte[SB_RAB] = rx_abort;
        sbyte[SB_CRC] = rx_crc_ok;
        sbyte[SB_CR] = rx_cr & cr_ok;
        sbyte[SB_SA+:2] = rx_sapi & {2{cr_ok}};
        sbyte[SB_TA] = rx_tei & ta_ok;
    end

    // next state
    always_comb begin
        n = r;
        ev_set = '0;
        rinc = 1'b0;
        rdec = '0;
        xinc = 1'b0;
        xdec = 1'b0;
        qpush = 1'b0;
        qpop = 1'b0;
        qin = '0;
        rclr = cmd & pwdata[C_RXRES];
        xclr = 1'b0;
        n.tv = 1'b0;
        n.tf = 1'b0;
        n.tl = 1'b0;
        n.ta = 1'b0;

        // read data captured in the setup phase
        if (setup & ~pwrite) begin
            unique case (paddr)
                ADR_DATA: n.prdata = {24'h0, (r.roff < ravail) ? r.rm[rptr] : r.rlast};
                ADR_IRQ: n.prdata = {24'h0, r.irq};
                ADR_STAT: n.prdata = {30'h0, ~r.xlock & ~r.xdrop & (xfree >= bs), r.tx_overflow_flag};
                ADR_XMODE: n.prdata = {24'h0, r.xmode};
                ADR_CNTL: n.prdata = {24'h0, r.cntl};
                ADR_CNTH: n.prdata = {27'h0, r.cnth};
                ADR_MODE: n.prdata = {29'h0, r.mode};
                default: n.prdata = '0;
            endcase
        end

        // receive data read, only inside the available bytes
        if (rdacc && paddr == ADR_DATA && r.roff < ravail) begin
            n.roff = r.roff + 7'h01;
            n.rlast = r.rm[rptr];
        end
        // event status read clears, unlocks transmit writes
        if (rdacc && paddr == ADR_IRQ) begin
            n.irq = '0;
            n.xdrop = 1'b0;
        end
        // mode registers
        if (wr && paddr == ADR_XMODE) begin
            n.xmode = pwdata[7:0];
        end
        if (wr && paddr == ADR_MODE) begin
            n.mode = pwdata[2:0];
        end

        // receive link side
        if (rx_sof) begin
            n.rin = 1'b1;
            n.rlost = (r.rused == DEPTH);
            n.rdov = 1'b0;
            n.rcnt = '0;
            n.rov = 1'b0;
            n.rfill = '0;
        end else if (rx_valid && r.rin && !r.rlost) begin
            if (r.rused < RX_DATA_MAX) begin
                n.rm[r.rwp] = rx_data;
                n.rwp = r.rwp + 6'h01;
                rinc = 1'b1;
                {n.rov, n.rcnt} = cinc;
                if ({1'b0, r.rfill} + 7'h01 == hfr_rx_thr(r.rthr)) begin
                    qpush = 1'b1;
                    qin.k = EV_POOL;
                    qin.len = r.rfill + 6'h01;
                    n.rfill = '0;
                end else begin
                    n.rfill = r.rfill + 6'h01;
                end
            end else begin
                n.rdov = 1'b1;
            end
        end else if (rx_eof && r.rin) begin
            n.rin = 1'b0;
            qpush = 1'b1;
            if (r.rlost) begin
                qin.k = EV_LOST;
            end else begin
                n.rm[r.rwp] = sbyte;
                n.rwp = r.rwp + 6'h01;
                rinc = 1'b1;
                {n.rov, n.rcnt} = cinc;
                qin.k = EV_END;
                qin.len = r.rfill + 6'h01;
                qin.cnt = cinc[11:0];
                qin.ov = cinc[12];
            end
        end

        // block acknowledge releases the whole block
        if (cmd && pwdata[C_RXACK]) begin
            n.rthr = r.xmode[XM_RX_BLOCK_SIZE_FIELD+:2];
            if (r.rown) begin
                n.rbase = r.rbase + r.rlen;
                rdec = {1'b0, r.rlen};
                n.rown = 1'b0;
                n.roff = '0;
            end
        end

        // hand the next queued event to the host once acknowledged
        if (!r.rown && r.qn != 3'h0) begin
            qpop = 1'b1;
            n.rown = 1'b1;
            n.roff = '0;
            n.rlen = qout.len;
            unique case (qout.k)
                EV_POOL: ev_set[I_RPF] = 1'b1;
                EV_END: begin
                    ev_set[I_RME] = 1'b1;
                    n.cntl = qout.cnt[7:0];
                    n.cnth = {qout.ov, qout.cnt[11:8]};
                end
                EV_LOST: begin
                    ev_set[I_RFO] = 1'b1;
                    n.rlen = '0;
                end
                default: n.rlen = '0;
            endcase
        end
        if (qpush && r.qn != 3'(QN)) begin
            n.q[r.qw] = qin;
            n.qw = r.qw + 2'h1;
        end
        if (qpop) begin
            n.qr = r.qr + 2'h1;
        end
        n.qn = r.qn + {2'h0, qpush && r.qn != 3'(QN)} - {2'h0, qpop};
        n.rused = r.rused + {6'h0, rinc} - rdec;
        if (rclr) begin
            n.rwp = '0;
            n.rbase = '0;
            n.rused = '0;
            n.rown = 1'b0;
            n.roff = '0;
            n.rin = 1'b0;
            n.qw = '0;
            n.qr = '0;
            n.qn = '0;
            n.rthr = r.xmode[XM_RX_BLOCK_SIZE_FIELD+:2];
        end

        // host writes into the transmit buffer
        if (wr && paddr == ADR_DATA && !r.xlock && !r.xdrop) begin
            n.xm[r.xwp] = pwdata[7:0];
            n.xwp = r.xwp + 6'h01;
            xinc = (r.xused != DEPTH);
            n.xblkw = r.xblkw + 7'h01;
            if (r.xblkw >= bs) begin
                n.tx_overflow_flag = 1'b1;
            end
        end

        // pool ready once a block of space is free
        if (r.xwait && xfree >= bs) begin
            ev_set[I_XPR] = 1'b1;
            n.xwait = 1'b0;
        end

        // transmit link side
        if (take) begin
            n.tv = 1'b1;
            n.td = r.xm[r.xrd];
            n.xrd = r.xrd + 6'h01;
            xdec = 1'b1;
            n.xsent = (r.xsent == 7'h7f) ? r.xsent : r.xsent + 7'h01;
            if (r.st == TX_IDLE) begin
                n.tf = 1'b1;
                n.xfs = r.xrd;
                n.xsent = 7'h01;
                n.st = TX_SEND;
            end
            if (r.xend_v && r.xrd + 6'h01 == r.xend) begin
                n.tl = 1'b1;
                n.xend_v = 1'b0;
                n.st = r.xlock ? TX_CLOSE : TX_IDLE;
            end
        end else if (tx_collision && r.st == TX_SEND) begin
            if (r.xsent > bs) begin
                ev_set[I_XMR] = 1'b1;
                ev_set[I_XPR] = 1'b1;
                n.xdrop = 1'b1;
                xclr = 1'b1;
            end else begin
                n.xrd = r.xfs;
                n.xused = r.xused + r.xsent;
                n.st = TX_IDLE;
            end
        end else if (tx_req && r.st == TX_SEND) begin
            ev_set[I_XDU] = 1'b1;
            ev_set[I_XPR] = 1'b1;
            n.xdrop = 1'b1;
            n.ta = 1'b1;
            xclr = 1'b1;
        end else if (tx_close_done && r.st == TX_CLOSE) begin
            ev_set[I_XPR] = 1'b1;
            n.xlock = 1'b0;
            n.ta = 1'b1;
            n.st = TX_IDLE;
        end
        if (!(tx_collision && r.st == TX_SEND && r.xsent <= bs)) begin
            n.xused = r.xused + {6'h0, xinc} - {6'h0, xdec};
        end

        // frame and end commands commit the written block
        if (cmd && (pwdata[C_TXF] || pwdata[C_TXME])) begin
            n.xcm = r.xwp;
            n.xblkw = '0;
            n.xbs = r.xmode[XM_TX_BLOCK_SIZE_BIT];
            if (pwdata[C_TXME]) begin
                n.xend_v = 1'b1;
                n.xend = r.xwp;
            end
            if (pwdata[C_TXF] && pwdata[C_TXME]) begin
                n.xlock = 1'b1;
            end else begin
                n.xwait = 1'b1;
            end
        end
        // transmitter reset, pending events kept
        if (cmd && pwdata[C_TXRES]) begin
            xclr = 1'b1;
            n.tx_overflow_flag = 1'b0;
            n.xbs = r.xmode[XM_TX_BLOCK_SIZE_BIT];
            n.ta = 1'b1;
            ev_set[I_XPR] = 1'b1;
        end
        if (xclr) begin
            n.xwp = '0;
            n.xrd = '0;
            n.xcm = '0;
            n.xused = '0;
            n.xend_v = 1'b0;
            n.xwait = 1'b0;
            n.xlock = 1'b0;
            n.xblkw = '0;
            n.st = TX_IDLE;
        end
        n.irq = n.irq | ev_set; // set wins over read clear
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.xmode <= XMODE_RST;
            r.mode <= MODE_RST;
            r.st <= TX_IDLE;
        end else if (ce) begin
            r <= n;
        end
    end

    // outputs from flip-flops
    assign prdata = r.prdata;
    assign tx_valid = r.tv;
    assign tx_data = r.td;
    assign tx_first = r.tf;
    assign tx_last = r.tl;
    assign tx_abort = r.ta;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_underrun;
        ce && tx_req && !tx_collision && r.st == TX_SEND && r.xrd == r.xcm;
    endsequence
    sequence s_close;
        ce && tx_close_done && r.st == TX_CLOSE && !tx_req;
    endsequence

    a_rx_data_ovf: assert property (ce && !rx_sof && rx_valid && r.rin && !r.rlost
        && r.rused >= RX_DATA_MAX |=> r.rdov) else $error("overflow flag not set");
    a_rx_lost_frame: assert property (ce && rx_sof && r.rused == DEPTH && !rclr
        |=> r.rlost) else $error("full buffer frame not lost");
    a_rx_read_repeat: assert property (ce && setup && !pwrite && paddr == ADR_DATA
        && r.roff >= ravail |=> r.prdata[7:0] == $past(r.rlast))
        else $error("read past data not repeated");
    a_rx_ack_release: assert property (ce && cmd && pwdata[C_RXACK] && !pwdata[C_RXRES]
        && r.rown |=> !r.rown && r.rbase == $past(r.rbase + r.rlen))
        else $error("block ack did not release");
    a_rx_status_store: assert property (ce && rx_eof && !rx_sof && !rx_valid && r.rin
        && !r.rlost && !rclr |=> r.rwp == $past(r.rwp) + 6'h01)
        else $error("status byte not stored");
    a_tx_reset_pool: assert property (ce && cmd && pwdata[C_TXRES]
        |=> r.irq[I_XPR] && r.xused == 7'h00 && tx_abort)
        else $error("reset did not clear and report");
    a_tx_underrun: assert property (s_underrun |=> r.irq[I_XDU] && r.irq[I_XPR]
        && tx_abort && r.xdrop && r.st == TX_IDLE) else $error("underrun not handled");
    a_tx_write_drop: assert property (ce && r.xdrop && wr && paddr == ADR_DATA
        |=> r.xwp == $past(r.xwp)) else $error("write taken while locked");
    a_tx_over_write: assert property (ce && wr && paddr == ADR_DATA && !r.xlock && !r.xdrop
        && r.xblkw >= bs && !cmd |=> r.tx_overflow_flag) else $error("overflow not flagged");
    a_tx_close_pool: assert property (s_close |=> r.irq[I_XPR] && !r.xlock && tx_abort)
        else $error("close not followed by pool ready");
    a_tx_size_hold: assert property (ce && !cmd |=> r.xbs == $past(r.xbs))
        else $error("block size changed without command");
    a_rx_event_hold: assert property (ce && r.rown && !(cmd && pwdata[C_RXACK])
        |=> r.qn >= $past(r.qn)) else $error("event given before ack");

endmodule : hfr_ctrl

// ---- hfr_link.sv ----
// partner model of the frame fifo link side
`timescale 1ns/10ps
module hfr_link (
    // clock, reset, bench control
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pull_en,
    // transmit link
    input wire logic tx_last,
    output logic tx_req,
    output logic tx_collision,
    output logic tx_close_done,
    // receive link
    output logic rx_sof,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_eof,
    output logic [6:0] rx_st
);
    logic [2:0] gap_r;
    // random byte requests; closing flag shortly after last byte
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_req <= 1'b0;
            tx_close_done <= 1'b0;
            gap_r <= 3'h0;
        end else begin
            tx_req <= pull_en && ($urandom_range(2) != 0);
            gap_r <= tx_last ? 3'h3 : (gap_r != 3'h0 ? gap_r - 3'h1 : 3'h0);
            tx_close_done <= gap_r == 3'h1;
        end
    end
    assign tx_collision = 1'b0; // no collisions
    // receive lines idle at time zero
    initial begin
        {rx_sof, rx_valid, rx_eof, rx_data, rx_st} = '0;
    end
    // one frame: start, counting bytes, end with status
    task automatic rx_frame(input int n, input logic [7:0] base, input logic [6:0] st);
        @(posedge pclk);
        rx_sof <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_sof <= 1'b0;
            rx_valid <= 1'b1;
            rx_data <= base + 8'(i);
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_eof <= 1'b1;
        rx_st <= st;
        rx_data <= ~rx_data; // invert stale byte
        @(posedge pclk);
        rx_eof <= 1'b0;
        rx_st <= ~st;
    endtask : rx_frame
endmodule : hfr_link

// ---- hfr_pkg.sv ----
// constants, types and helpers for the frame fifo controller
package hfr_pkg;
    // register byte offsets
    localparam logic [7:0] ADR_DATA = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_IRQ = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0c;
    localparam logic [7:0] ADR_XMODE = 8'h10;
    localparam logic [7:0] ADR_CNTL = 8'h14;
    localparam logic [7:0] ADR_CNTH = 8'h18;
    localparam logic [7:0] ADR_MODE = 8'h1c;
    // command_reg bits
    localparam int C_RXACK = 0;
    localparam int C_TXF = 1;
    localparam int C_TXME = 2;
    localparam int C_TXRES = 3;
    localparam int C_RXRES = 4;
    // frame_irq_status_reg bits
    localparam int I_RPF = 7;
    localparam int I_RME = 6;
    localparam int I_RFO = 5;
    localparam int I_XPR = 4;
    localparam int I_XMR = 3;
    localparam int I_XDU = 2;
    // general_status_reg bits
    localparam int S_TX_OVERFLOW_FLAG = 0;
    localparam int S_XFW = 1;
    // extended_mode_reg fields, reset values and mode codes
    localparam int XM_TX_BLOCK_SIZE_BIT = 5;
    localparam int XM_RX_BLOCK_SIZE_FIELD = 3;
    localparam logic [7:0] XMODE_RST = 8'h00;
    localparam logic [2:0] MODE_RST = 3'h3;
    localparam logic [2:0] MODE_NA2 = 3'h3;
    localparam logic [2:0] MODE_T0 = 3'h6;
    localparam logic [2:0] MODE_T1 = 3'h7;
    // status byte bit positions
    localparam int SB_VFR = 7;
    localparam int SB_RDO = 6;
    localparam int SB_RAB = 5;
    localparam int SB_CRC = 4;
    localparam int SB_CR = 3;
    localparam int SB_SA = 1;
    localparam int SB_TA = 0;
    // buffer sizes
    localparam logic [6:0] DEPTH = 7'h40;
    localparam logic [6:0] RX_DATA_MAX = 7'h3f;
    localparam logic [6:0] BLK32 = 7'h20;
    localparam logic [6:0] BLK16 = 7'h10;
    localparam logic [11:0] CNT_MAX = 12'hfff;
    localparam int QN = 4;

    typedef enum logic [1:0] {EV_POOL = 2'b00, EV_END = 2'b01, EV_LOST = 2'b10} hfr_ev_e;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_CLOSE = 2'b10} hfr_tx_e;
    typedef struct packed {
        hfr_ev_e k;
        logic [5:0] len;
        logic [11:0] cnt;
        logic ov;
    } hfr_ev_s;

    // receive threshold from the two-bit field
    function automatic logic [6:0] hfr_rx_thr(input logic [1:0] f);
        return BLK32 >> f;
    endfunction : hfr_rx_thr

    // transmit threshold from the block size bit
    function automatic logic [6:0] hfr_tx_thr(input logic b);
        return b ? BLK16 : BLK32;
    endfunction : hfr_tx_thr
endpackage : hfr_pkg

// ---- tb.sv ----
// bench for the frame fifo controller
`timescale 1ns/10ps
module tb;
    import hfr_pkg::*;
    typedef struct packed {
        logic [32:0] d;
        logic [32:0] m;
    } hfr_note_s;
    // wiring
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, pull_en;
    logic [7:0] paddr, rx_data, tx_data, base;
    logic [31:0] pwdata, prdata, last_rd, acc;
    logic rx_sof, rx_valid, rx_eof, tx_req, tx_collision, tx_close_done;
    logic tx_valid, tx_first, tx_last, tx_abort;
    logic [6:0] rx_st, f;
    // bookkeeping
    int fail_count, checks, aborts, na;
    hfr_note_s rd_q[$];
    logic [9:0] tx_q[$];
    logic [2:0] modes [3] = '{MODE_NA2, MODE_T0, MODE_T1};

    hfr_ctrl i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_sof(rx_sof), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_eof(rx_eof), .rx_crc_ok(rx_st[4]), .rx_vfr(rx_st[6]),
        .rx_abort(rx_st[5]), .rx_cr(rx_st[3]), .rx_sapi(rx_st[2:1]), .rx_tei(rx_st[0]),
        .tx_req(tx_req), .tx_collision(tx_collision), .tx_close_done(tx_close_done),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last),
        .tx_abort(tx_abort)
    );
    hfr_link i_link (
        .pclk(pclk), .presetn(presetn), .pull_en(pull_en), .tx_last(tx_last),
        .tx_req(tx_req), .tx_collision(tx_collision), .tx_close_done(tx_close_done),
        .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
        .rx_st(rx_st)
    );
    // 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // apb: setup, access until pready, idle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            fail_count++;
            $display("mismatch %0t no pready", $time);
        end
        last_rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        rd_q.push_back({e, m});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // random transmit bytes, noted if sent
    task automatic txw(input int n, input logic fl, input logic keep);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (keep) tx_q.push_back({i == 0, fl && i == n - 1, b});
            wr(ADR_DATA, {24'h0, b});
        end
    endtask : txw
    task automatic rxrd(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) rd(ADR_DATA, {25'h0, b + 8'(i)}, 33'hff);
    endtask : rxrd
    task automatic wabort(input int n0);
        for (int i = 0; i < 400 && aborts <= n0; i++) @(posedge pclk);
        checks++;
        if (aborts <= n0) begin
            fail_count++;
            $display("mismatch %0t no abort sent", $time);
        end
    endtask : wabort
    // status byte as mode reports it
    function automatic logic [7:0] sb_of(input logic [6:0] s, input logic [2:0] m);
        logic a, t;
        a = (m == MODE_NA2) || (m == MODE_T1);
        t = (m != MODE_T0) && (m != MODE_T1);
        return {s[6], 1'b0, s[5], s[4], s[3] & a, s[2:1] & {2{a}}, s[0] & t};
    endfunction : sb_of
    task automatic print_verdict();
        checks++;
        if (rd_q.size() != 0 || tx_q.size() != 0) begin
            fail_count++;
            $display("mismatch %0t notes left unanswered", $time);
        end
        $display("fail_count %0d checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // compare results with oldest note, away from the launching edge
    always @(negedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() > 0) begin
            checks++;
            if ((({pslverr, prdata} ^ rd_q[0].d) & rd_q[0].m) !== 33'h0) begin
                fail_count++;
                $display("mismatch %0t read at %h gave %h", $time, paddr, prdata);
            end
            rd_q.delete(0);
        end
        if (tx_valid === 1'b1) begin
            checks++;
            if (tx_q.size() == 0 || {tx_first, tx_last, tx_data} !== tx_q[0]) begin
                fail_count++;
                $display("mismatch %0t sent byte %h", $time, tx_data);
            end
            if (tx_q.size() > 0) tx_q.delete(0);
        end
        if (tx_abort === 1'b1) aborts++;
    end
    // watchdog
    initial begin
        repeat (30000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        {ce, psel, penable, pwrite, pull_en} = 5'b10000;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(81));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADR_XMODE, {25'h0, XMODE_RST}, 33'hff);
        rd(ADR_MODE, {30'h0, MODE_RST}, 33'h7);
        rd(8'h20, 33'h100000000, 33'h1ffffffff);
        // tx reset: abort, pool ready kept
        na = aborts;
        wr(ADR_CMD, 32'h1 << C_TXRES);
        wabort(na);
        rd(ADR_IRQ, 33'h10, 33'h1c);
        rd(ADR_IRQ, 33'h0, 33'h1c);
        rd(ADR_STAT, 33'h2, 33'h3);
        // block sizes 32, 16, latched by command
        for (int k = 0; k < 2; k++) begin
            wr(ADR_XMODE, k == 1 ? 32'h20 : 32'h0);
            wr(ADR_CMD, 32'h1 << C_TXRES);
            wr(ADR_XMODE, k == 1 ? 32'h0 : 32'h20);
            txw(k == 1 ? 16 : 32, 1'b0, 1'b0);
            rd(ADR_STAT, 33'h0, 33'h1);
            wr(ADR_DATA, 32'h5a);
            rd(ADR_STAT, 33'h1, 33'h1);
            wr(ADR_CMD, 32'h1 << C_TXRES);
            rd(ADR_IRQ, 33'h10, 33'h1c);
        end
        // frame with end: locked until the closing flag
        txw(20, 1'b1, 1'b1);
        wr(ADR_CMD, 32'h6);
        wr(ADR_DATA, 32'ha5);
        rd(ADR_STAT, 33'h0, 33'h2);
        rd(ADR_IRQ, 33'h0, 33'h10);
        na = aborts;
        pull_en <= 1'b1;
        wabort(na);
        pull_en <= 1'b0;
        rd(ADR_IRQ, 33'h10, 33'h1c);
        // frame runs dry: underrun, writes refused
        txw(4, 1'b0, 1'b1);
        wr(ADR_CMD, 32'h1 << C_TXF);
        rd(ADR_IRQ, 33'h10, 33'h1c);
        na = aborts;
        pull_en <= 1'b1;
        wabort(na);
        pull_en <= 1'b0;
        wr(ADR_DATA, 32'h3c);
        rd(ADR_IRQ, 33'h14, 33'h1c);
        txw(2, 1'b1, 1'b1);
        na = aborts;
        wr(ADR_CMD, 32'h6);
        pull_en <= 1'b1;
        wabort(na);
        pull_en <= 1'b0;
        // short frame per mode: data, status, repeat
        foreach (modes[k]) begin
            wr(ADR_MODE, {29'h0, modes[k]});
            wr(ADR_CMD, 32'h1 << C_RXRES);
            f = 7'($urandom);
            base = 8'($urandom);
            i_link.rx_frame(5, base, f);
            repeat (3) @(posedge pclk);
            rd(ADR_IRQ, 33'h40, 33'he0);
            rd(ADR_CNTL, 33'h6, 33'hff);
            rd(ADR_CNTH, 33'h0, 33'h1f);
            rxrd(base, 5);
            rd(ADR_DATA, {25'h0, sb_of(f, modes[k])}, 33'hff);
            rd(ADR_DATA, {25'h0, sb_of(f, modes[k])}, 33'hff);
            wr(ADR_CMD, 32'h1 << C_RXACK);
        end
        // block of four: held until ack, unread dropped
        wr(ADR_MODE, {29'h0, MODE_NA2});
        wr(ADR_XMODE, 32'h18);
        wr(ADR_CMD, 32'h1 << C_RXRES);
        f = 7'($urandom);
        base = 8'($urandom);
        i_link.rx_frame(6, base, f);
        repeat (3) @(posedge pclk);
        rd(ADR_IRQ, 33'h80, 33'he0);
        rd(ADR_IRQ, 33'h0, 33'he0);
        rxrd(base, 2);
        wr(ADR_CMD, 32'h1 << C_RXACK);
        rd(ADR_IRQ, 33'h40, 33'he0);
        rd(ADR_CNTL, 33'h7, 33'hff);
        rxrd(base + 8'h4, 2);
        rd(ADR_DATA, {25'h0, sb_of(f, MODE_NA2)}, 33'hff);
        wr(ADR_CMD, 32'h1 << C_RXACK);
        // overrun then lost frame
        wr(ADR_XMODE, 32'h0);
        wr(ADR_CMD, 32'h1 << C_RXRES);
        i_link.rx_frame(70, 8'h00, 7'h50);
        i_link.rx_frame(1, 8'h80, 7'h50);
        acc = 32'h0;
        repeat (4) begin
            repeat (3) @(posedge pclk);
            rd(ADR_IRQ, 33'h0, 33'h0);
            acc = acc | last_rd;
            wr(ADR_CMD, 32'h1 << C_RXACK);
        end
        checks++;
        if (acc[I_RFO] !== 1'b1 || acc[I_RME] !== 1'b1) begin
            fail_count++;
            $display("mismatch %0t overrun events %h", $time, acc);
        end
        print_verdict();
    end
endmodule : tb
